// File: include/icc_pkg.sv
// Constants, register map and types of the input capture channel.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// Function
// (RULE1) Falling mode captures every falling edge
// (RULE2) Rising mode captures every rising edge
// (RULE3) Divide-by-four mode captures every fourth rise
// (RULE4) Divide-by-sixteen mode captures every sixteenth rise
// (RULE5) Both-edges mode captures rise and fall
// (RULE6) Wake mode flags edges during sleep/idle
// (RULE7) Own 16-bit synchronous up-counting timer
// (RULE8) Capture pushes own timer value
// (RULE9) Timer readable, lags live count slightly
// (RULE10) Cascade out/in pairs timers to 32 bits
// (RULE11) Five-bit sync source select resets timer
// (RULE12) Four-deep capture buffer read via port
// (RULE13) Interrupt after selected number of captures
// (RULE14) Stop-in-idle bit halts channel in idle
// (RULE15) Three-bit mode field encodes channel modes
// (RULE16) Overflow flag reads one after overflow
// (RULE17) Not-empty bit shows unread captures exist
// (RULE18) Source 111 selects system clock for timer
// (RULE19) Capture into full buffer sets overflow, dropped
// (RULE20) Buffer read returns oldest and removes it
package icc_pkg;
	// ====================================================
	// Register byte offsets
	localparam logic [7:0] ICC_CON1_OFS = 8'h00;
	localparam logic [7:0] ICC_CON2_OFS = 8'h04;
	localparam logic [7:0] ICC_FIFO_OFS = 8'h08;
	localparam logic [7:0] ICC_TMR_OFS  = 8'h0C;
	// ====================================================
	// Control one field positions
	localparam int ICC_SIDL_BIT = 13;
	localparam int ICC_TSEL_LSB = 10;
	localparam int ICC_CPI_LSB  = 5;
	localparam int ICC_OV_BIT   = 4;
	localparam int ICC_NE_BIT   = 3;
	localparam int ICC_MODE_LSB = 0;
	// Control two field positions
	localparam int ICC_CASC_BIT = 8;
	localparam int ICC_SYNC_LSB = 0;
	// ====================================================
	// Reset values
	localparam logic [15:0] ICC_CON1_RST = 16'h0000;
	localparam logic [4:0]  ICC_SYNC_RST = 5'h0D;
	// Buffer depth and timer source code for system clock
	localparam int          ICC_DEPTH    = 4;
	localparam logic [2:0]  ICC_TSEL_SYS = 3'h7;
	// ====================================================
	// Channel modes
	typedef enum logic [2:0] {
		ICC_OFF    = 3'b000,
		ICC_EVERY  = 3'b001,
		ICC_FALL   = 3'b010,
		ICC_RISE   = 3'b011,
		ICC_RISE4  = 3'b100,
		ICC_RISE16 = 3'b101,
		ICC_UNUSED = 3'b110,
		ICC_WAKE   = 3'b111
	} icc_mode_t;
endpackage

// File: core/icc_fifo.sv
// Four-entry capture buffer with overflow tracking.
// Assumes push and pop are single-cycle pulses in the system clock.
`timescale 1ns/1ps
`default_nettype none
module icc_fifo import icc_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Write side
	input  wire logic        push,
	input  wire logic [15:0] push_data,
	// Read side
	input  wire logic        pop,
	output logic      [15:0] head,
	output logic             not_empty,
	// Overflow control
	input  wire logic        ovf_clr,
	output logic             ovf
);
	// ====================================================
	// Storage
	logic [15:0] mem_q [ICC_DEPTH];  // Entries
	logic [15:0] mem_d [ICC_DEPTH];
	logic [1:0]  wp_q, wp_d;          // Write pointer
	logic [1:0]  rp_q, rp_d;          // Read pointer
	logic [2:0]  cnt_q, cnt_d;        // Fill level
	logic        ovf_q, ovf_d;        // Sticky overflow
	logic        do_push, do_pop;

	// Next state
	always_comb begin
		mem_d   = mem_q;
		wp_d    = wp_q;
		rp_d    = rp_q;
		cnt_d   = cnt_q;
		ovf_d   = ovf_q;
		do_pop  = pop && (cnt_q != 3'd0);
		// Full buffer drops the new value, unless a pop frees room
		do_push = push && ((cnt_q != 3'd4) || do_pop);  // RULE19
		if (ovf_clr) begin
			ovf_d = 1'b0;
		end
		if (push && !do_push) begin
			ovf_d = 1'b1;  // RULE19 RULE16
		end
		if (do_push) begin
			mem_d[wp_q] = push_data;  // RULE12
			wp_d        = wp_q + 2'd1;
		end
		if (do_pop) begin
			rp_d = rp_q + 2'd1;  // RULE20
		end
		cnt_d = cnt_q + {2'd0, do_push} - {2'd0, do_pop};
	end

	// Registers
	always_ff @(posedge clk) begin
		if (srst) begin
			wp_q  <= 2'd0;
			rp_q  <= 2'd0;
			cnt_q <= 3'd0;
			ovf_q <= 1'b0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
		end
		mem_q <= mem_d;  // Data needs no reset
	end

	assign head      = mem_q[rp_q];
	assign not_empty = (cnt_q != 3'd0);  // RULE17
	assign ovf       = ovf_q;
endmodule
`default_nettype wire

// File: core/icc_channel.sv
// Input capture channel top: Wishbone slave, timer, edge logic.
// Assumes pin, timer ticks, sync and power states are synchronous to clk.
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module icc_channel import icc_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Capture pin
	input  wire logic        capture_input_pin,
	// Timer clock enables, index by source select
	input  wire logic [7:0]  timer_tick,
	// Sync sources, index by sync select
	input  wire logic [31:0] sync_in,
	// Cascade
	input  wire logic        cascade_in,
	output logic             cascade_out,
	// Power states
	input  wire logic        cpu_idle,
	input  wire logic        cpu_sleep,
	// Interrupt and wake
	output logic             capture_irq,
	output logic             wake_req
);
	// ====================================================
	// Helpers
	function automatic logic is_rd(input logic [7:0] a, input logic [7:0] o);
		return (a == o);
	endfunction

	// Prescaler end test, shared by both divide modes
	function automatic logic pre_last(input logic [3:0] p, input logic [3:0] last);
		return (p == last);
	endfunction

	// ====================================================
	// Register state
	logic [15:0] con1_q, con1_d;      // Control one, writable bits
	logic [4:0]  sync_q, sync_d;      // Sync select
	logic        casc_q, casc_d;      // Cascade enable
	logic [15:0] tmr_q, tmr_d;        // Channel timer
	logic [15:0] tmr_rd_q, tmr_rd_d;  // Read-back copy, one cycle late
	logic        pin_q, pin_d;        // Previous pin level
	logic [3:0]  pre_q, pre_d;        // Rising-edge prescaler
	logic [1:0]  evc_q, evc_d;        // Capture count toward interrupt
	logic        irq_q, irq_d;
	logic        wake_q, wake_d;
	logic        cout_q, cout_d;
	logic        ack_q, ack_d;
	logic [31:0] dat_q, dat_d;

	// Fifo links
	logic        push, pop, ovf_clr, ne, ovf;
	logic [15:0] head;

	// Decoded controls
	icc_mode_t   mode;
	logic        sidl, halted, rise, fall, cap, tick, sync_hit, bus_req;
	logic [2:0]  tsel;
	logic [1:0]  cpi;

	assign mode    = icc_mode_t'(con1_q[ICC_MODE_LSB +: 3]);  // RULE15
	assign sidl    = con1_q[ICC_SIDL_BIT];
	assign tsel    = con1_q[ICC_TSEL_LSB +: 3];
	assign cpi     = con1_q[ICC_CPI_LSB +: 2];
	assign halted  = sidl && cpu_idle;  // RULE14
	// Edges compare the pin with the previous clock's sample
	assign rise    = capture_input_pin && !pin_q;
	assign fall    = !capture_input_pin && pin_q;
	// System clock source counts every cycle
	assign tick    = (tsel == ICC_TSEL_SYS) ? 1'b1 : timer_tick[tsel];  // RULE18
	assign sync_hit = sync_in[sync_q];  // RULE11
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;

	// ====================================================
	// Capture event decode
	// A halted channel neither captures nor moves its prescaler
	always_comb begin
		pre_d  = pre_q;
		pin_d  = capture_input_pin;  // Sampled even while off, so enabling sees no stale edge
		cap    = 1'b0;
		wake_d = 1'b0;
		if (!halted) begin
			case (mode)
				// Plain edge modes drop any partial prescale count
				ICC_EVERY: begin
					cap   = rise || fall;  // RULE5
					pre_d = 4'd0;
				end
				ICC_FALL: begin
					cap   = fall;  // RULE1
					pre_d = 4'd0;
				end
				ICC_RISE: begin
					cap   = rise;  // RULE2
					pre_d = 4'd0;
				end
				// Divide modes count rises and capture on the last one
				ICC_RISE4: begin
					if (rise) begin
						pre_d = pre_last(pre_q, 4'd3) ? 4'd0 : pre_q + 4'd1;
						cap   = pre_last(pre_q, 4'd3);  // RULE3
					end
				end
				ICC_RISE16: begin
					if (rise) begin
						pre_d = pre_q + 4'd1;  // Wraps to zero after the sixteenth
						cap   = pre_last(pre_q, 4'd15);  // RULE4
					end
				end
				// Wake mode stores nothing, it only flags the edge
				ICC_WAKE: begin
					wake_d = rise && (cpu_sleep || cpu_idle);  // RULE6
					pre_d  = 4'd0;
				end
				// Off and unused
				default: begin
					pre_d = 4'd0;
				end
			endcase
		end
	end

	// ====================================================
	// Timer, interrupt count, cascade
	always_comb begin
		tmr_d    = tmr_q;
		cout_d   = 1'b0;
		evc_d    = evc_q;
		irq_d    = 1'b0;
		tmr_rd_d = tmr_q;  // RULE9
		// Off and unused modes freeze the timer
		if (mode != ICC_OFF && mode != ICC_UNUSED && !halted) begin
			// A sync pulse wins over a count in the same cycle
			// Cascade input replaces the local tick when paired
			if (sync_hit) begin
				tmr_d = 16'h0000;  // RULE11
			end else if (casc_q ? cascade_in : tick) begin
				tmr_d  = tmr_q + 16'h0001;  // RULE7 RULE10
				cout_d = (tmr_q == 16'hFFFF);  // RULE10
			end
		end
		// Count field holds captures per interrupt minus one
		if (cap) begin
			// Every-edge mode ignores the count field
			if (mode == ICC_EVERY || evc_q == cpi) begin
				irq_d = 1'b1;  // RULE13
				evc_d = 2'd0;
			end else begin
				evc_d = evc_q + 2'd1;
			end
		end
		if (mode == ICC_OFF) begin
			evc_d = 2'd0;
		end
	end
	assign push = cap;  // RULE8

	// ====================================================
	// Wishbone slave: ack one cycle after request
	always_comb begin
		con1_d  = con1_q;
		sync_d  = sync_q;
		casc_d  = casc_q;
		ack_d   = bus_req;
		dat_d   = dat_q;
		pop     = 1'b0;
		ovf_clr = 1'b0;
		if (bus_req && wb_we_i) begin
			if (is_rd(wb_adr_i, ICC_CON1_OFS)) begin
				// Lane 0: mode and count; status bits stay read-only
				if (wb_sel_i[0]) begin
					con1_d[7:0] = wb_dat_i[7:0] & 8'h67;
				end
				if (wb_sel_i[1]) begin
					con1_d[15:8] = wb_dat_i[15:8] & 8'h3C;
				end
				// Turning the channel off clears overflow
				if (wb_sel_i[0] && wb_dat_i[2:0] == 3'b000) begin
					ovf_clr = 1'b1;
				end
			end else if (is_rd(wb_adr_i, ICC_CON2_OFS)) begin
				if (wb_sel_i[0]) begin
					sync_d = wb_dat_i[ICC_SYNC_LSB +: 5];
				end
				// Lane 1 holds only the cascade enable
				if (wb_sel_i[1]) begin
					casc_d = wb_dat_i[ICC_CASC_BIT];
				end
			end
		end else if (bus_req) begin
			// Only a buffer read has a side effect, the pop
			dat_d = 32'h0000_0000;  // Unmapped reads zero
			if (is_rd(wb_adr_i, ICC_CON1_OFS)) begin
				dat_d[15:0] = con1_q;
				dat_d[ICC_OV_BIT] = ovf;  // RULE16
				dat_d[ICC_NE_BIT] = ne;   // RULE17
			end else if (is_rd(wb_adr_i, ICC_CON2_OFS)) begin
				dat_d[ICC_CASC_BIT]      = casc_q;
				dat_d[ICC_SYNC_LSB +: 5] = sync_q;
			end else if (is_rd(wb_adr_i, ICC_FIFO_OFS)) begin
				dat_d[15:0] = head;  // RULE20
				pop = 1'b1;          // RULE20
			end else if (is_rd(wb_adr_i, ICC_TMR_OFS)) begin
				dat_d[15:0] = tmr_rd_q;  // RULE9
			end
		end
	end

	// ====================================================
	// Control registers
	// Only the bus writes these; reset leaves the channel off
	always_ff @(posedge clk) begin
		if (srst) begin
			con1_q <= ICC_CON1_RST;
			sync_q <= ICC_SYNC_RST;
			casc_q <= 1'b0;
		end else begin
			con1_q <= con1_d;
			sync_q <= sync_d;
			casc_q <= casc_d;
		end
	end

	// ====================================================
	// Timer, interrupt count and cascade registers
	always_ff @(posedge clk) begin
		if (srst) begin
			tmr_q    <= 16'h0000;
			tmr_rd_q <= 16'h0000;
			evc_q    <= 2'd0;
			irq_q    <= 1'b0;
			cout_q   <= 1'b0;
		end else begin
			tmr_q    <= tmr_d;
			tmr_rd_q <= tmr_rd_d;
			evc_q    <= evc_d;
			irq_q    <= irq_d;
			cout_q   <= cout_d;
		end
	end

	// ====================================================
	// Edge detect registers
	// Pin sample resets low; a pin that idles high shows a
	// rise here, harmless since the channel is off after reset
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_q  <= 1'b0;
			pre_q  <= 4'h0;
			wake_q <= 1'b0;
		end else begin
			pin_q  <= pin_d;
			pre_q  <= pre_d;
			wake_q <= wake_d;
		end
	end

	// ====================================================
	// Bus reply registers
	always_ff @(posedge clk) begin
		if (srst) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	// ====================================================
	// Capture buffer
	// Pushes the live timer; pops on each buffer read
	icc_fifo u_fifo (
		.clk       (clk),
		.srst      (srst),
		.push      (push),
		.push_data (tmr_q),
		.pop       (pop),
		.head      (head),
		.not_empty (ne),
		.ovf_clr   (ovf_clr),
		.ovf       (ovf)
	);

	// Outputs from flops
	// Registered pulses keep glitches off the bus and the core
	assign wb_ack_o    = ack_q;
	assign wb_dat_o    = dat_q;
	assign capture_irq = irq_q;
	assign wake_req    = wake_q;
	assign cascade_out = cout_q;
endmodule
`default_nettype wire

// File: testbench/icc_assertions.sv
// Port-level checker for the input capture channel.
// Assumes it is bound to icc_channel, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module icc_assertions (
	// Clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// Bus and channel ports
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        capture_input_pin,
	input wire logic        cpu_idle,
	input wire logic        cpu_sleep,
	input wire logic        cascade_out,
	input wire logic        capture_irq,
	input wire logic        wake_req
);
	// ==========================================
	// Single domain, reset disables everything
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
	a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper bits");
	a_irq_from_edge: assert property (capture_irq |-> $past(capture_input_pin) != $past(capture_input_pin, 2)) else $error("irq w/o edge");
	a_irq_one_cycle: assert property (capture_irq |=> !capture_irq) else $error("irq held");
	a_wake_cause: assert property (wake_req |-> $past(capture_input_pin) && !$past(capture_input_pin, 2) && $past(cpu_sleep || cpu_idle)) else $error("bad wake");
	a_casc_one_cycle: assert property (cascade_out |=> !cascade_out) else $error("cascade held");
	a_reset_quiet: assert property ($past(srst) |-> !wb_ack_o && !capture_irq && !wake_req && !cascade_out) else $error("busy after reset");
	// Main scenarios reached
	c_irq: cover property (capture_irq);
	c_wake: cover property (wake_req);
	c_ack: cover property (wb_ack_o);
	c_casc: cover property (cascade_out);
endmodule
`default_nettype wire

// File: testbench/icc_pin_model.sv
// External signal source driving the capture pin.
// Assumes the pin is sampled on clk; changes land just after an edge.
`timescale 1ns/1ps
`default_nettype none
module icc_pin_model (
	// Clock
	input wire logic clk,
	// Driven pin
	output var logic pin
);
	// Idle low until the first edge
	initial pin = 1'b0;
	// Toggle n times, gap clocks apart; even n ends low again
	task automatic toggle(input int n, input int gap);
		repeat (n) begin
			repeat (gap) @(posedge clk);
			pin <= ~pin;
		end
	endtask
endmodule
`default_nettype wire

// File: testbench/tb_input_capture_channel.sv
// Self-checking bench for the input capture channel.
// Assumes timer source 7 counts every clk; sync and cascade come from the bench.
`timescale 1ns/1ps
`default_nettype none
module tb_input_capture_channel;
	import icc_pkg::*;
	logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, idle = 0, sleep = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000, rdat, r, prev, ovb;
	logic [31:0] sync = 32'h0000_0000;
	logic ack, pin, irq, wake, cout, cin = 0;
	int fails = 0, n_tests = 0, wakes = 0, irqs = 0, couts = 0, cnt;
	icc_mode_t modes [5] = '{ICC_FALL, ICC_RISE, ICC_EVERY, ICC_RISE4, ICC_RISE16};
	int caps [5] = '{16, 16, 32, 4, 1};
	int gaps [5] = '{6, 6, 3, 24, 0};
	// Captures per interrupt field, and the interrupts each mode yields
	int ci [5] = '{1, 3, 3, 0, 0};
	int nirq [5] = '{8, 4, 32, 4, 1};
	always #50 clk = ~clk;
	icc_pin_model pin_u (.clk(clk), .pin(pin));
	icc_channel dut_u (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.capture_input_pin(pin), .timer_tick(8'h00), .sync_in(sync), .cascade_in(cin),
		.cascade_out(cout), .cpu_idle(idle), .cpu_sleep(sleep), .capture_irq(irq), .wake_req(wake));
	// Count output pulses
	always @(posedge clk) begin
		if (wake === 1'b1) wakes++;
		if (irq === 1'b1) irqs++;
		if (cout === 1'b1) couts++;
	end
	// One classic cycle; holds until ack is seen
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
		do @(posedge clk); while (ack !== 1'b1);
		r = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (80000) @(posedge clk);
		fails++;
		report_and_stop;
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		wb(0, ICC_CON1_OFS, 0); chk(r, 32'h0000_0000);
		wb(0, ICC_CON2_OFS, 0); chk(r, {27'h0, ICC_SYNC_RST});
		wb(0, 8'h10, 0); chk(r, 32'h0000_0000);
		// Each mode: 16 rising, 16 falling edges, 3 clocks apart
		for (int m = 0; m < 5; m++) begin
			wb(1, ICC_CON1_OFS, 32'h1C00 | (ci[m] << 5) | modes[m]);
			irqs = 0;
			pin_u.toggle(32, 3);
			repeat (4) @(posedge clk);
			wb(0, ICC_CON1_OFS, 0);
			ovb = (caps[m] > 4) ? 32'h0000_0010 : 32'h0000_0000;
			chk(r, 32'h1C08 | (ci[m] << 5) | modes[m] | ovb);
			chk(irqs, nirq[m]);
			cnt = 0;
			while (r[3] === 1'b1 && cnt < 6) begin
				wb(0, ICC_FIFO_OFS, 0);
				if (cnt > 0) chk({16'h0000, r[15:0] - prev[15:0]}, gaps[m]);
				prev = r;
				cnt++;
				wb(0, ICC_CON1_OFS, 0);
			end
			chk(cnt, (caps[m] > 4) ? 4 : caps[m]);
			wb(1, ICC_CON1_OFS, 0);
		end
		// Wake mode: edge in sleep wakes, nothing stored
		wb(1, ICC_CON1_OFS, 32'h0007);
		sleep <= 1'b1;
		pin_u.toggle(2, 3);
		repeat (3) @(posedge clk);
		sleep <= 1'b0;
		chk(wakes, 1);
		wb(0, ICC_CON1_OFS, 0); chk(r, 32'h0007);
		// Stop in idle halts, resumes on leaving idle
		wb(1, ICC_CON1_OFS, 32'h3C03);
		idle <= 1'b1;
		wb(0, ICC_TMR_OFS, 0);
		prev = r;
		wb(0, ICC_TMR_OFS, 0);
		chk({16'h0000, r[15:0] - prev[15:0]}, 32'h0000_0000);
		pin_u.toggle(4, 3);
		wb(0, ICC_CON1_OFS, 0); chk(r, 32'h3C03);
		idle <= 1'b0;
		pin_u.toggle(2, 3);
		repeat (3) @(posedge clk);
		wb(0, ICC_CON1_OFS, 0); chk(r, 32'h3C0B);
		// Timer runs on every clock; read-back trails by one
		wb(0, ICC_TMR_OFS, 0);
		prev = r;
		wb(0, ICC_TMR_OFS, 0);
		chk({16'h0000, r[15:0] - prev[15:0]}, 32'h0000_0003);
		// Held sync source keeps the timer at zero
		sync <= 32'h0000_0001 << ICC_SYNC_RST;
		repeat (2) @(posedge clk);
		wb(0, ICC_TMR_OFS, 0);
		chk(r, 32'h0000_0000);
		// Free run from zero wraps exactly once
		couts = 0;
		sync <= 32'h0000_0000;
		repeat (65540) @(posedge clk);
		chk(couts, 1);
		// Cascade input replaces the local count
		wb(1, ICC_CON2_OFS, 32'h0000_0100 | ICC_SYNC_RST);
		wb(0, ICC_CON2_OFS, 0);
		chk(r, 32'h0000_0100 | ICC_SYNC_RST);
		cin <= 1'b1;
		wb(0, ICC_TMR_OFS, 0);
		prev = r;
		wb(0, ICC_TMR_OFS, 0);
		chk({16'h0000, r[15:0] - prev[15:0]}, 32'h0000_0003);
		cin <= 1'b0;
		wb(0, ICC_TMR_OFS, 0);
		prev = r;
		wb(0, ICC_TMR_OFS, 0);
		chk({16'h0000, r[15:0] - prev[15:0]}, 32'h0000_0000);
		report_and_stop;
	end
endmodule
bind icc_channel icc_assertions chk_u (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .capture_input_pin(capture_input_pin),
	.cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .cascade_out(cascade_out), .capture_irq(capture_irq),
	.wake_req(wake_req));
`default_nettype wire
